// *** verilog/csp_port.sv ***
// Serial access port of the calendar: select, serial clock, data line.
// Assumes link pins are asynchronous and much slower than mclk.
`timescale 1ns/1ps
`default_nettype none

module csp_port
  import csp_pkg::*;
(
  input  wire logic           mclk,
  input  wire logic           resetn,
  input  wire logic           ce,
  input  wire logic           transfer_select,
  input  wire logic           serial_clock,
  input  wire logic           serial_data_line_in,
  output logic                serial_data_line_out,
  output logic                serial_data_line_oe,
  input  wire csp_pkg::csp_cwr_t core_wr,
  input  wire logic           lost_clear,
  output logic                write_lost,
  output logic                oscillator_stop_bit,
  output logic                write_protect
);
  import csp_pkg::*;

  // Synchronisers: first stage feeds only the second
  logic       sel_m, sel_s, sck_m, sck_s, sck_d, sdi_m, sdi_s;
  logic       rise, fall;
  // Transfer engine
  csp_state_t state, next_state;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [7:0] shreg, next_shreg;
  logic [7:0] cmd;
  logic       burst, next_burst;
  logic [2:0] addr, next_addr;
  logic [7:0] rd_byte, next_rd_byte;
  logic       rd_pend, next_rd_pend;
  logic       mem_re, next_mem_re;
  logic       next_out, next_oe;
  logic       push, next_push;
  csp_entry_t push_ent, next_push_ent;
  logic       next_lost;
  // Drain side
  logic       fifo_in_ready, fifo_out_valid, drain_ok, drain_en;
  csp_entry_t fifo_out;
  logic       mem_we;
  csp_entry_t mem_w;
  logic [7:0] mem_rdata;
  logic       next_stop, next_wp;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, frozen with the transfer_select while ce is low
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      {sel_m, sel_s, sck_m, sck_s, sck_d, sdi_m, sdi_s} <= '0;
    end
    else if (ce)
    begin
      sel_m <= transfer_select;
      sel_s <= sel_m;
      sck_m <= serial_clock;
      sck_s <= sck_m;
      sck_d <= sck_s;
      sdi_m <= serial_data_line_in;
      sdi_s <= sdi_m;
    end
  end

  // Edges seen after synchronising, one per serial edge
  assign rise = ce & sck_s & ~sck_d;
  assign fall = ce & ~sck_s & sck_d;
  assign cmd  = {sdi_s, shreg[7:1]};

  ////////////////////////////////////////////////////////////////////////
  // Transfer engine
  always_comb
  begin
    next_state    = state;
    next_bit_cnt  = bit_cnt;
    next_shreg    = shreg;
    next_burst    = burst;
    next_addr     = addr;
    next_rd_byte  = rd_pend ? mem_rdata : rd_byte;
    next_rd_pend  = mem_re; // Image data stand one cycle after the strobe
    next_mem_re   = 1'b0;
    next_out      = serial_data_line_out;
    next_oe       = serial_data_line_oe;
    next_push     = 1'b0;
    next_push_ent = push_ent;
    // Set wins over the clear
    next_lost     = (write_lost & ~lost_clear) | (push & ~fifo_in_ready);
    if (!sel_s)
    begin
      // Abort and release the line
      next_state   = ST_IDLE;
      next_bit_cnt = 3'h0;
      next_oe      = 1'b0;
      next_out     = 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          next_state   = ST_CMD;
          next_bit_cnt = 3'h0;
        end
        ST_CMD:
        begin
          if (rise)
          begin
            next_shreg   = cmd;
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == 3'h7)
            begin
              next_burst = csp_is_burst(cmd);
              next_addr  = csp_is_burst(cmd) ? 3'h0 : cmd[CMD_ADR_MSB:CMD_ADR_LSB];
              if (cmd[7:4] == CMD_TEST && cmd[CMD_DIR_BIT])
                next_state = ST_IGNORE; // Test read commands are not served; test writes go to ST_WR
              else if (cmd[CMD_DIR_BIT])
              begin
                // Fetch now; line is driven at the very next fall
                next_state   = ST_RD;
                next_mem_re  = 1'b1;
              end
              else
                next_state = ST_WR;
            end
          end
        end
        ST_WR:
        begin
          if (rise)
          begin
            next_shreg   = cmd;
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == 3'h7)
            begin
              // Lock register is never written by a burst
              next_push          = ~(burst && addr == ADR_WPROT);
              next_push_ent.addr = addr;
              next_push_ent.data = cmd;
              if (burst && addr != ADR_WPROT)
                next_addr = addr + 3'h1;
              else
                next_state = ST_IGNORE;
            end
          end
        end
        ST_RD:
        begin
          if (fall)
          begin
            next_out     = rd_byte[bit_cnt];
            next_oe      = 1'b1;
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == 3'h7 && burst)
            begin
              // Next byte is ready long before the following fall
              next_addr    = addr + 3'h1;
              next_mem_re  = 1'b1;
            end
          end
        end
        ST_IGNORE:
        begin
          next_state = ST_IGNORE;
        end
        default:
        begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      state                <= ST_IDLE;
      bit_cnt              <= 3'h0;
      shreg                <= 8'h00;
      burst                <= 1'b0;
      addr                 <= 3'h0;
      rd_byte              <= 8'h00;
      rd_pend              <= 1'b0;
      mem_re               <= 1'b0;
      serial_data_line_out <= 1'b0;
      serial_data_line_oe  <= 1'b0;
      push                 <= 1'b0;
      push_ent             <= '0;
      write_lost           <= 1'b0;
    end
    else if (ce)
    begin
      state                <= next_state;
      bit_cnt              <= next_bit_cnt;
      shreg                <= next_shreg;
      burst                <= next_burst;
      addr                 <= next_addr;
      rd_byte              <= next_rd_byte;
      rd_pend              <= next_rd_pend;
      mem_re               <= next_mem_re;
      serial_data_line_out <= next_out;
      serial_data_line_oe  <= next_oe;
      push                 <= next_push;
      push_ent             <= next_push_ent;
      write_lost           <= next_lost;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write buffer; the core's own writes stall the drain
  csp_fifo #(
    .WIDTH ($bits(csp_entry_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (mclk),
    .resetn    (resetn),
    .ce        (ce),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (push_ent),
    .out_valid (fifo_out_valid),
    .out_ready (~core_wr.en),
    .out_data  (fifo_out)
  );

  // Locked writes are drained and dropped, except to the lock itself
  assign drain_ok = fifo_out_valid & ~core_wr.en;
  assign drain_en = drain_ok & (~write_protect | fifo_out.addr == ADR_WPROT);
  assign mem_we   = core_wr.en | drain_en;
  assign mem_w    = core_wr.en ? core_wr.ent : fifo_out;

  // Limitation: a read may see data still waiting in the buffer as old
  csp_regmem u_regs (
    .clk    (mclk),
    .resetn (resetn),
    .ce     (ce),
    .we     (mem_we),
    .waddr  (mem_w.addr),
    .wdata  (mem_w.data),
    .re     (mem_re),
    .raddr  (addr),
    .rdata  (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // Mirrors of stop and lock bits
  always_comb
  begin
    next_stop = oscillator_stop_bit;
    next_wp   = write_protect;
    if (mem_we && mem_w.addr == ADR_SECS)
      next_stop = mem_w.data[STOP_BIT];
    if (mem_we && mem_w.addr == ADR_WPROT)
      next_wp = mem_w.data[WPROT_BIT];
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      oscillator_stop_bit <= STOP_RESET;
      write_protect       <= WP_RESET;
    end
    else if (ce)
    begin
      oscillator_stop_bit <= next_stop;
      write_protect       <= next_wp;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  // Direction is command bit 0, already in the shifter at the eighth rise
  sequence s_last_cmd_read;
    state == ST_CMD && sel_s && rise && bit_cnt == 3'h7 && cmd[CMD_DIR_BIT]
      && cmd[7:4] != CMD_TEST;
  endsequence

  sequence s_first_fall;
    state == ST_RD && fall && !serial_data_line_oe;
  endsequence

  a_wr_push_cause: assert property (push |-> $past(state) == ST_WR && $past(rise)
    && $past(bit_cnt) == 3'h7) else $error("push without eighth write bit");
  a_ignore_no_push: assert property ((state == ST_IGNORE && ce) |=> !push)
    else $error("write after ignored clocks");
  a_lsb_first_in: assert property ((state == ST_CMD && rise) |=> shreg[7] == $past(sdi_s)
    && shreg[6:0] == $past(shreg[7:1])) else $error("input shift order");
  a_read_bit_out: assert property ((state == ST_RD && fall) |=> serial_data_line_oe
    && serial_data_line_out == $past(rd_byte[bit_cnt])) else $error("read bit");
  a_no_turnaround: assert property (s_last_cmd_read |=> (state == ST_RD && mem_re)
    ##1 rd_pend ##1 rd_byte == $past(mem_rdata)) else $error("read fetch late");
  a_first_drive: assert property (s_first_fall |=> serial_data_line_oe)
    else $error("line not driven at first fall");
  a_single_repeat: assert property ((state == ST_RD && !burst && !rd_pend && ce)
    |=> $stable(rd_byte)) else $error("single read byte changed");
  a_sel_low_hiz: assert property ((!sel_s && ce) |=> !serial_data_line_oe
    && state == ST_IDLE) else $error("line driven without select");
  a_one_bit_edge: assert property ((state inside {ST_CMD, ST_WR} && sel_s && rise)
    |=> bit_cnt == $past(bit_cnt) + 3'h1) else $error("bit count step");
  a_burst_start: assert property ((state == ST_CMD && sel_s && rise && bit_cnt == 3'h7
    && csp_is_burst(cmd)) |=> addr == 3'h0 && burst) else $error("burst start");
  a_shift_on_rise: assert property ((ce && sel_s && !rise && state != ST_IDLE)
    |=> $stable(shreg)) else $error("input shifted off a rising edge");

endmodule // csp_port

`default_nettype wire

// *** verilog/csp_pkg.sv ***
// Shared types and constants of the calendar serial access port.
// Assumes one system clock domain; the serial link pins are sampled into it.
`default_nettype none

package csp_pkg;

  // Command byte layout, shifted in bit 0 first
  localparam int unsigned CMD_BITS    = 8;
  localparam int unsigned CMD_DIR_BIT = 0;
  localparam int unsigned CMD_ADR_LSB = 1;
  localparam int unsigned CMD_ADR_MSB = 3;
  localparam logic [6:0]  CMD_BURST   = 7'h5f;  // Bits 7..1 of a burst command
  localparam logic [3:0]  CMD_TEST    = 4'h9;   // Bits 7..4 of a test command

  // Calendar register image
  localparam int unsigned REG_COUNT  = 8;
  localparam logic [2:0]  ADR_SECS   = 3'h0;
  localparam logic [2:0]  ADR_WPROT  = 3'h7;
  localparam int unsigned STOP_BIT   = 7;       // Oscillator stop bit in seconds
  localparam int unsigned WPROT_BIT  = 7;       // Write lock bit in its register
  localparam logic [7:0]  REG_RESET  = 8'h00;
  localparam logic        STOP_RESET = 1'b0;
  localparam logic        WP_RESET   = 1'b0;

  // Write buffer
  localparam int unsigned FIFO_DEPTH = 16;

  // One register write: address and data
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] data;
  } csp_entry_t;

  // Write port of the timekeeping core
  typedef struct packed {
    logic       en;
    csp_entry_t ent;
  } csp_cwr_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_WR,
    ST_RD,
    ST_IGNORE
  } csp_state_t;

  // Burst selection from bits 7..1 of the command
  function automatic logic csp_is_burst(input logic [7:0] c);
    return c[7:1] == CMD_BURST;
  endfunction

endpackage

`default_nettype wire

// *** verilog/csp_fifo.sv ***
// Write buffer between the serial side and the register image.
// Assumes one clock; both sides use valid and ready.
`timescale 1ns/1ps
`default_nettype none

module csp_fifo #(
  parameter int unsigned WIDTH = 11,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
    begin : g_bad
      $error("csp_fifo: DEPTH must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr;
  logic [AW:0]      rptr;
  logic [AW:0]      next_wptr;
  logic [AW:0]      next_rptr;
  logic             push;
  logic             pop;

  ////////////////////////////////////////////////////////////////////////
  // Extra pointer bit tells full from empty
  assign in_ready  = (wptr[AW] == rptr[AW]) || (wptr[AW-1:0] != rptr[AW-1:0]);
  assign out_valid = wptr != rptr;
  assign out_data  = mem[rptr[AW-1:0]];
  assign push      = ce & in_valid & in_ready;
  assign pop       = ce & out_valid & out_ready;

  always_comb
  begin
    next_wptr = push ? wptr + 1'b1 : wptr;
    next_rptr = pop ? rptr + 1'b1 : rptr;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wptr <= '0;
      rptr <= '0;
    end
    else
    begin
      wptr <= next_wptr;
      rptr <= next_rptr;
    end
  end

  // Storage needs no reset; empty pointers hide stale words
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wptr[AW-1:0]] <= in_data;
  end

endmodule // csp_fifo

`default_nettype wire

// *** verilog/csp_regmem.sv ***
// Eight-word calendar register image with one write and one read port.
// Assumes one clock; read data appear one cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none

module csp_regmem
  import csp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       ce,
  input  wire logic       we,
  input  wire logic [2:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic       re,
  input  wire logic [2:0] raddr,
  output logic      [7:0] rdata
);
  logic [7:0] mem [REG_COUNT];
  logic [7:0] next_rdata;

  ////////////////////////////////////////////////////////////////////////
  // Read before write on a shared address
  always_comb
  begin
    next_rdata = re ? mem[raddr] : rdata;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata <= REG_RESET;
      for (int i = 0; i < REG_COUNT; i++)
        mem[i] <= REG_RESET;
    end
    else if (ce)
    begin
      rdata <= next_rdata;
      if (we)
        mem[waddr] <= wdata;
    end
  end

endmodule // csp_regmem

`default_nettype wire

// *** dv/csp_host.sv ***
// Host model for the calendar serial port: select, serial clock, data.
// Assumes the bench resolves the data wire and calls xfer at a falling mclk.
`timescale 1ns/1ps
`default_nettype none

module csp_host (
  output logic      transfer_select,
  output logic      serial_clock,
  output logic      host_oe,
  output logic      host_d,
  input  wire logic line
);
  logic [7:0] wbuf [0:9];
  logic [7:0] rbuf [0:9];

  // Idle: clock parked low, line released
  initial
  begin
    transfer_select = 1'b0;
    serial_clock    = 1'b0;
    host_oe         = 1'b0;
    host_d          = 1'b0;
  end

  ////////////////////////////////////////
  // One 80 ns period: data set at the fall, taken at the rise
  task automatic bit_cyc(input logic drive, input logic d, output logic s);
    host_oe = drive;
    host_d = d;
    #40 serial_clock = 1'b1;
    s = line;
    #40 serial_clock = 1'b0;
  endtask

  // Command then nbits data bits; direction follows command bit 0
  task automatic xfer(input logic [7:0] cmd, input int nbits);
    logic s;
    transfer_select = 1'b1;
    #40;
    for (int i = 0; i < 8; i++)
      bit_cyc(1'b1, cmd[i], s);
    for (int k = 0; k < nbits; k++)
    begin
      bit_cyc(!cmd[0], wbuf[k/8][k%8], s);
      rbuf[k/8][k%8] = s;
    end
    host_oe = 1'b0;
    #40 transfer_select = 1'b0;
    #200;
  endtask
endmodule // csp_host

`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench of the calendar serial port with a host model.
// Assumes csp_pkg and the port are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb;
  import csp_pkg::*;
  logic       mclk, resetn, ce, lost_clear, float_q, line;
  logic       transfer_select, serial_clock, host_oe, host_d;
  logic       line_out, line_oe, write_lost, stop_bit, wprot, oe_seen;
  csp_cwr_t   core_wr;
  int         error_cnt, total_checks, cycles, seed;
  logic [7:0] model [0:7];
  logic [7:0] d, old;
  logic [2:0] a;

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Released wire shows a toggling level, never a stale bit
  always @(posedge mclk)
    float_q <= ~float_q;
  assign line = line_oe ? line_out : (host_oe ? host_d : float_q);

  csp_host host_u (.transfer_select(transfer_select), .serial_clock(serial_clock),
    .host_oe(host_oe), .host_d(host_d), .line(line));

  csp_port dut_u (.mclk(mclk), .resetn(resetn), .ce(ce), .transfer_select(transfer_select),
    .serial_clock(serial_clock), .serial_data_line_in(line), .serial_data_line_out(line_out),
    .serial_data_line_oe(line_oe), .core_wr(core_wr), .lost_clear(lost_clear),
    .write_lost(write_lost), .oscillator_stop_bit(stop_bit), .write_protect(wprot));

  ////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Write lock spares register 7 in single mode; burst never writes it
  function automatic logic wr_takes(input logic [2:0] ad, input logic burst);
    if (burst && ad == ADR_WPROT)
      return 1'b0;
    if (model[ADR_WPROT][WPROT_BIT] && ad != ADR_WPROT)
      return 1'b0;
    return 1'b1;
  endfunction

  // Single write with four stray clocks after the byte
  task automatic wr1(input logic [2:0] ad, input logic [7:0] dat);
    host_u.wbuf[0] = dat;
    host_u.wbuf[1] = 8'($random(seed));
    host_u.xfer({4'h8, ad, 1'b0}, 12);
    if (wr_takes(ad, 1'b0))
      model[ad] = dat;
  endtask

  // Single read of n bytes; every byte repeats the register
  task automatic rd1(input logic [2:0] ad, input int n);
    host_u.xfer({4'h8, ad, 1'b1}, 8 * n);
    for (int b = 0; b < n; b++)
      chk("read byte", model[ad], host_u.rbuf[b]);
    chk("oe after select low", 8'h00, {7'h0, line_oe});
  endtask

  // Hang guard well above the expected run length
  always @(posedge mclk)
  begin
    cycles++;
    if (line_oe === 1'b1)
      oe_seen = 1'b1;
    if (line_oe === 1'b1 && host_oe === 1'b1)
      chk("both drive", 8'h00, 8'h01);
    if (cycles == 60000)
    begin
      error_cnt++;
      $display("test timeout");
      tally_and_finish();
    end
  end

  ////////////////////////////////////////
  initial
  begin
    resetn = 1'b0;
    ce = 1'b1;
    lost_clear = 1'b0;
    core_wr = '0;
    float_q = 1'b0;
    oe_seen = 1'b0;
    error_cnt = 0;
    total_checks = 0;
    cycles = 0;
    seed = 53865;
    for (int i = 0; i < 8; i++)
      model[i] = REG_RESET;
    repeat (4) @(posedge mclk);
    @(negedge mclk) resetn = 1'b1;
    chk("reset outputs", 8'h00, {3'h0, line_out, line_oe, write_lost, stop_bit, wprot});
    $display("test reset done");

    // Random single writes and repeated reads, plus the stop mirror
    repeat (6)
    begin
      a = 3'(($random(seed) & 32'h7fff) % 7);
      wr1(a, 8'($random(seed)));
      rd1(a, 2);
    end
    wr1(ADR_SECS, 8'h80);
    chk("stop mirror", 8'h01, {7'h0, stop_bit});
    wr1(ADR_SECS, 8'h00);
    chk("stop mirror", 8'h00, {7'h0, stop_bit});
    $display("test single done");

    // Write lock refuses ordinary registers, lock register still open
    wr1(ADR_WPROT, 8'h80);
    chk("lock mirror", 8'h01, {7'h0, wprot});
    wr1(3'h3, ~model[3]);
    rd1(3'h3, 1);
    wr1(ADR_WPROT, 8'h00);
    chk("lock mirror", 8'h00, {7'h0, wprot});
    $display("test lock done");

    // Burst write then a nine-byte burst read that wraps
    for (int b = 0; b < 8; b++)
      host_u.wbuf[b] = 8'($random(seed));
    host_u.xfer(8'hbe, 64);
    for (int b = 0; b < 8; b++)
      if (wr_takes(3'(b), 1'b1))
        model[b] = host_u.wbuf[b];
    host_u.xfer(8'hbf, 72);
    for (int b = 0; b < 8; b++)
      chk("burst byte", model[b], host_u.rbuf[b]);
    chk("burst wrap", model[0], host_u.rbuf[8]);
    chk("stop mirror", {7'h0, model[0][STOP_BIT]}, {7'h0, stop_bit});
    $display("test burst done");

    // Select dropped after five data bits leaves the register alone
    host_u.wbuf[0] = ~model[2];
    host_u.xfer(8'h84, 5);
    rd1(3'h2, 1);
    // Test command: the line must never be driven
    oe_seen = 1'b0;
    host_u.xfer(8'h97, 8);
    chk("test command oe", 8'h00, {7'h0, oe_seen});
    $display("test abort done");

    // Core writes starve the drain: sixteen buffered, the next lost
    @(negedge mclk);
    core_wr.ent.addr = 3'h6;
    core_wr.ent.data = 8'hc3;
    core_wr.en = 1'b1;
    for (int i = 0; i < 17; i++)
    begin
      a = 3'(i % 5 + 1);
      old = model[a];
      wr1(a, 8'($random(seed)));
      if (i == 16)
        model[a] = old;
    end
    chk("lost flag", 8'h01, {7'h0, write_lost});
    // Enable low: a clear request must not reach the flag
    ce = 1'b0;
    lost_clear = 1'b1;
    repeat (3) @(negedge mclk);
    chk("frozen lost flag", 8'h01, {7'h0, write_lost});
    lost_clear = 1'b0;
    ce = 1'b1;
    @(negedge mclk) core_wr.en = 1'b0;
    model[6] = 8'hc3;
    repeat (40) @(negedge mclk);
    lost_clear = 1'b1;
    @(negedge mclk) lost_clear = 1'b0;
    @(negedge mclk);
    chk("lost cleared", 8'h00, {7'h0, write_lost});
    for (int i = 1; i < 7; i++)
      rd1(3'(i), 1);
    $display("test buffer done");
    tally_and_finish();
  end
endmodule // tb

`default_nettype wire
